// ==== src/fcu_flash_ctrl.sv ====
// Program flash write and erase controller with its table access registers.
`timescale 1ns/1ps

// Notes on behaviour
// - Word mode start programs exactly two bytes from the holding latch.
// - Block mode start programs all 64 holding latch bytes.
// - With erase selected, a start erases the pointed block instead.
// - With erase clear, a start only programs and never erases.
// - Nothing is written or erased unless the permit bit is set.
// - The permit bit is clear after power-up.
// - Fault flag sets with start and clears when the timer finishes.
// - Fault flag stays set after an aborted or improper start.
// - Software can only set the start bit; writing zero does nothing.
// - Hardware clears the start bit when the operation completes.
// - The unlock port stores nothing and always reads as zero.
// - Unlock port writes matter only as part of the start sequence.
module fcu_flash_ctrl #(
    parameter logic [fcu_pkg::TMR_W-1:0] PROG_CYCLES = fcu_pkg::TMR_W'(fcu_pkg::PROG_CYCLES_DEF),
    parameter logic [fcu_pkg::TMR_W-1:0] ERASE_CYCLES = fcu_pkg::TMR_W'(fcu_pkg::ERASE_CYCLES_DEF)
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic warm_rst,
    input wire fcu_pkg::fcu_sfr_s sfr,
    input wire fcu_pkg::fcu_tbl_s tbl,
    input wire logic [7:0] flash_rdata,
    output logic [7:0] sfr_rdata,
    output fcu_pkg::fcu_flash_s flash,
    output logic busy
);
    import fcu_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] latch;
        logic [PTR_W-1:0] ptr;
        logic word;
        logic free;
        logic fault;
        logic permit;
        logic start;
        logic [HOLD_BYTES-1:0][7:0] hold;
        fcu_state_e st;
        logic [6:0] cnt;
        logic [PTR_W-1:0] op_addr;
        logic rd_pend;
        logic [7:0] rdata;
        fcu_flash_s fl;
    } fcu_ctrl_s;

    fcu_ctrl_s s_r;
    fcu_ctrl_s s_nxt;
    logic armed;
    logic tmr_done;
    logic tmr_start;
    logic [TMR_W-1:0] tmr_load;
    logic accept;
    logic ctrl_wr;
    logic start_req;

    // Decoded strobes used by the sequence logic and the checks; the unlock detector's strobes are decoded at its port connections below.
    assign ctrl_wr = sfr.wr && (sfr.addr == ADDR_CONTROL);
    assign start_req = ctrl_wr && sfr.wdata[BIT_START] && !s_r.start;
    assign accept = start_req && armed && sfr.wdata[BIT_PERMIT] && (s_r.st == ST_IDLE);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    fcu_unlock u_unlock (
        .clock(clock),
        .rst(rst),
        .warm_rst(warm_rst),
        .key_wr(sfr.wr && (sfr.addr == ADDR_UNLOCK)),
        .key_data(sfr.wdata),
        .other_wr(sfr.wr && (sfr.addr != ADDR_UNLOCK)),
        .armed(armed)
    );

    fcu_op_timer #(
        .W(TMR_W)
    ) u_timer (
        .clock(clock),
        .rst(rst),
        .abort(warm_rst),
        .start(tmr_start),
        .load(tmr_load),
        .done(tmr_done)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Sequencer first, then software and table accesses, so that a hardware
    // set of the fault flag is never lost to a clear in the same cycle.
    always_comb begin
        s_nxt = s_r;
        s_nxt.fl.rd = 1'b0;
        s_nxt.fl.prog = 1'b0;
        s_nxt.fl.erase = 1'b0;
        s_nxt.fl.wdata = ZERO_BYTE;
        s_nxt.rd_pend = 1'b0;
        s_nxt.rdata = ZERO_BYTE;
        tmr_start = 1'b0;
        tmr_load = '0;

        // Operation sequencer.
        unique case (s_r.st)
            ST_IDLE: begin
            end
            ST_STREAM: begin
                s_nxt.fl.prog = 1'b1;
                s_nxt.fl.addr = s_r.op_addr;
                s_nxt.fl.wdata = s_r.hold[s_r.op_addr[HOLD_IDX_W-1:0]];
                s_nxt.op_addr = s_r.op_addr + PTR_W'(1);
                s_nxt.cnt = s_r.cnt - LAST_COUNT;
                if (s_r.cnt == LAST_COUNT) begin
                    s_nxt.st = ST_WAIT;
                    tmr_start = 1'b1;
                    tmr_load = PROG_CYCLES;
                end
            end
            ST_ERASE: begin
                s_nxt.fl.erase = 1'b1;
                s_nxt.fl.addr = s_r.op_addr;
                s_nxt.st = ST_WAIT;
                tmr_start = 1'b1;
                tmr_load = ERASE_CYCLES;
            end
            ST_WAIT: begin
                if (tmr_done) begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.start = 1'b0;
                    s_nxt.fault = 1'b0;
                end
            end
        endcase

        // Register reads answer one cycle later; unknown addresses read zero.
        if (sfr.rd) begin
            case (sfr.addr)
                ADDR_CONTROL: s_nxt.rdata = {2'b00, s_r.word, s_r.free, s_r.fault, s_r.permit, s_r.start, 1'b0};
                ADDR_UNLOCK: s_nxt.rdata = ZERO_BYTE;
                ADDR_LATCH: s_nxt.rdata = s_r.latch;
                ADDR_PTR_LOW: s_nxt.rdata = s_r.ptr[7:0];
                ADDR_PTR_HIGH: s_nxt.rdata = s_r.ptr[15:8];
                ADDR_PTR_UPPER: s_nxt.rdata = {2'b00, s_r.ptr[PTR_W-1:16]};
                default: s_nxt.rdata = ZERO_BYTE;
            endcase
        end

        // Register writes; mode bits are frozen while an operation runs.
        if (sfr.wr) begin
            case (sfr.addr)
                ADDR_CONTROL: begin
                    if (s_r.st == ST_IDLE) begin
                        s_nxt.word = sfr.wdata[BIT_WORD];
                        s_nxt.free = sfr.wdata[BIT_ERASE];
                        s_nxt.permit = sfr.wdata[BIT_PERMIT];
                    end
                    if (!sfr.wdata[BIT_FAULT]) begin
                        s_nxt.fault = 1'b0;
                    end
                end
                ADDR_LATCH: s_nxt.latch = sfr.wdata;
                ADDR_PTR_LOW: s_nxt.ptr[7:0] = sfr.wdata;
                ADDR_PTR_HIGH: s_nxt.ptr[15:8] = sfr.wdata;
                ADDR_PTR_UPPER: s_nxt.ptr[PTR_W-1:16] = sfr.wdata[UPPER_W-1:0];
                default: begin
                end
            endcase
        end

        // Start request: a zero in the start bit never clears it.
        if (accept) begin
            s_nxt.start = 1'b1;
            s_nxt.fault = 1'b1;
            if (sfr.wdata[BIT_ERASE]) begin
                s_nxt.st = ST_ERASE;
                s_nxt.op_addr = {s_r.ptr[PTR_W-1:ERASE_ALIGN_W], ERASE_ALIGN_W'(0)};
            end else if (sfr.wdata[BIT_WORD]) begin
                s_nxt.st = ST_STREAM;
                s_nxt.cnt = WORD_COUNT;
                s_nxt.op_addr = {s_r.ptr[PTR_W-1:1], 1'b0};
            end else begin
                s_nxt.st = ST_STREAM;
                s_nxt.cnt = BLOCK_COUNT;
                s_nxt.op_addr = {s_r.ptr[PTR_W-1:HOLD_IDX_W], HOLD_IDX_W'(0)};
            end
        end else if (start_req) begin
            s_nxt.fault = 1'b1;
        end

        // Table instructions; flash reads are served only while idle.
        if (tbl.wt_op) begin
            s_nxt.hold[s_r.ptr[HOLD_IDX_W-1:0]] = s_r.latch;
        end
        if (tbl.rd_op && (s_r.st == ST_IDLE)) begin
            s_nxt.fl.rd = 1'b1;
            s_nxt.fl.addr = s_r.ptr;
            s_nxt.rd_pend = 1'b1;
        end
        if (s_r.rd_pend) begin
            s_nxt.latch = flash_rdata;
        end

        // Warm reset aborts the operation but keeps the fault flag.
        if (warm_rst) begin
            s_nxt.st = ST_IDLE;
            s_nxt.start = 1'b0;
            s_nxt.permit = 1'b0;
            s_nxt.word = 1'b0;
            s_nxt.free = 1'b0;
            s_nxt.cnt = '0;
            s_nxt.rd_pend = 1'b0;
            s_nxt.fl.rd = 1'b0;
            s_nxt.fl.prog = 1'b0;
            s_nxt.fl.erase = 1'b0;
        end
    end

    // Registers the whole controller state; power-up clears permit.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register.
    assign sfr_rdata = s_r.rdata;
    assign flash = s_r.fl;
    assign busy = s_r.start;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence seq_word_burst;
        ##2 s_r.fl.prog [*2] ##1 !s_r.fl.prog;
    endsequence

    sequence seq_erase_pulse;
        ##2 (s_r.fl.erase && !s_r.fl.prog) ##1 !s_r.fl.erase;
    endsequence

    chk_word_two_bytes: assert property (@(posedge clock) disable iff (rst || warm_rst)
        accept && !sfr.wdata[BIT_ERASE] && sfr.wdata[BIT_WORD] |-> seq_word_burst)
        else $error("word program did not emit exactly two bytes");

    chk_block_load: assert property (@(posedge clock) disable iff (rst || warm_rst)
        accept && !sfr.wdata[BIT_ERASE] && !sfr.wdata[BIT_WORD] |=> s_r.st == ST_STREAM && s_r.cnt == BLOCK_COUNT)
        else $error("block program did not load a 64 byte count");

    chk_block_step: assert property (@(posedge clock) disable iff (rst || warm_rst)
        s_r.st == ST_STREAM && s_r.cnt > LAST_COUNT |=> s_r.st == ST_STREAM && s_r.cnt == $past(s_r.cnt) - LAST_COUNT)
        else $error("byte stream skipped or stalled");

    chk_erase_only: assert property (@(posedge clock) disable iff (rst || warm_rst)
        accept && sfr.wdata[BIT_ERASE] |-> seq_erase_pulse)
        else $error("erase start did not give one erase pulse");

    chk_prog_no_erase: assert property (@(posedge clock) disable iff (rst)
        s_r.fl.prog |-> !s_r.fl.erase && !s_r.free)
        else $error("programming overlapped an erase selection");

    chk_start_gate: assert property (@(posedge clock) disable iff (rst || warm_rst)
        start_req && !(armed && sfr.wdata[BIT_PERMIT]) |=> !s_r.start && s_r.fault && s_r.st == ST_IDLE)
        else $error("start taken without unlock or permit");

    chk_start_flag: assert property (@(posedge clock) disable iff (rst || warm_rst)
        accept |=> s_r.start && s_r.fault && s_r.st != ST_IDLE)
        else $error("start did not set start and fault");

    chk_done_clears: assert property (@(posedge clock) disable iff (rst || warm_rst)
        s_r.st == ST_WAIT && tmr_done |=> !s_r.start && !s_r.fault && s_r.st == ST_IDLE)
        else $error("completion did not clear start and fault");

    chk_zero_keeps_start: assert property (@(posedge clock) disable iff (rst || warm_rst)
        s_r.start && ctrl_wr && !sfr.wdata[BIT_START] && !tmr_done |=> s_r.start)
        else $error("software cleared the start bit");

    chk_unlock_zero: assert property (@(posedge clock) disable iff (rst)
        sfr.rd && sfr.addr == ADDR_UNLOCK |=> sfr_rdata == ZERO_BYTE)
        else $error("unlock port read was not zero");

    chk_table_read: assert property (@(posedge clock) disable iff (rst || warm_rst)
        tbl.rd_op && s_r.st == ST_IDLE |=> flash.rd ##1 s_r.latch == $past(flash_rdata))
        else $error("table read did not load the flash byte");

    // A warm reset must not let a byte or an erase slip out of an aborted run.
    chk_warm_quiet: assert property (@(posedge clock) disable iff (rst)
        warm_rst |=> !s_r.fl.prog && !s_r.fl.erase && !s_r.fl.rd && !s_r.start)
        else $error("warm reset let a flash pulse through");

endmodule // fcu_flash_ctrl

// ==== src/fcu_pkg.sv ====
// Shared constants and types of the program flash write and erase controller.
package fcu_pkg;

    // ------------------------------------------------------------------
    // Register addresses on the core's special function register port
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CONTROL = 12'hFA6;
    localparam logic [11:0] ADDR_UNLOCK = 12'hFA7;
    localparam logic [11:0] ADDR_LATCH = 12'hFF5;
    localparam logic [11:0] ADDR_PTR_LOW = 12'hFF6;
    localparam logic [11:0] ADDR_PTR_HIGH = 12'hFF7;
    localparam logic [11:0] ADDR_PTR_UPPER = 12'hFF8;

    // ------------------------------------------------------------------
    // Field positions of flash_control
    // ------------------------------------------------------------------
    localparam int BIT_START = 1;
    localparam int BIT_PERMIT = 2;
    localparam int BIT_FAULT = 3;
    localparam int BIT_ERASE = 4;
    localparam int BIT_WORD = 5;

    // ------------------------------------------------------------------
    // Geometry of the table pointer, holding latch and erase block
    // ------------------------------------------------------------------
    localparam int PTR_W = 22;
    localparam int UPPER_W = 6;
    localparam int HOLD_BYTES = 64;
    localparam int HOLD_IDX_W = 6;
    localparam int ERASE_ALIGN_W = 10;
    localparam logic [6:0] BLOCK_COUNT = 7'h40;
    localparam logic [6:0] WORD_COUNT = 7'h02;
    localparam logic [6:0] LAST_COUNT = 7'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Unlock pattern written twice to flash_unlock_port before a start.
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

    // ------------------------------------------------------------------
    // Timing of the internal programming timer
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int PROG_TIME_NS = 2800;
    localparam int ERASE_TIME_NS = 33000;
    localparam int TMR_W = 16;
    localparam int PROG_CYCLES_DEF = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int ERASE_CYCLES_DEF = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STREAM = 2'b01,
        ST_ERASE = 2'b10,
        ST_WAIT = 2'b11
    } fcu_state_e;

    typedef struct packed {
        logic [11:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } fcu_sfr_s;

    typedef struct packed {
        logic rd_op;
        logic wt_op;
    } fcu_tbl_s;

    typedef struct packed {
        logic [PTR_W-1:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic prog;
        logic erase;
    } fcu_flash_s;

endpackage

// ==== src/fcu_unlock.sv ====
// Detector for the two-write unlock pattern that must precede a start.
`timescale 1ns/1ps
module fcu_unlock (
    input wire logic clock,
    input wire logic rst,
    input wire logic warm_rst,
    input wire logic key_wr,
    input wire logic [7:0] key_data,
    input wire logic other_wr,
    output logic armed
);
    import fcu_pkg::*;

    typedef enum logic [1:0] {
        KEY_NONE = 2'b00,
        KEY_HALF = 2'b01,
        KEY_ARMED = 2'b10
    } fcu_key_e;

    typedef struct packed {
        fcu_key_e stage;
    } fcu_unlock_s;

    fcu_unlock_s s_r;
    fcu_unlock_s s_nxt;

    // Any write elsewhere breaks the pattern, so it must be back to back.
    always_comb begin
        s_nxt = s_r;
        if (warm_rst || other_wr) begin
            s_nxt.stage = KEY_NONE;
        end else if (key_wr) begin
            unique case (s_r.stage)
                KEY_NONE: s_nxt.stage = (key_data == UNLOCK_KEY_FIRST) ? KEY_HALF : KEY_NONE;
                KEY_HALF: s_nxt.stage = (key_data == UNLOCK_KEY_SECOND) ? KEY_ARMED : KEY_NONE;
                KEY_ARMED: s_nxt.stage = (key_data == UNLOCK_KEY_FIRST) ? KEY_HALF : KEY_NONE;
                default: s_nxt.stage = KEY_NONE;
            endcase
        end
    end

    // Registers the detector state.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign armed = (s_r.stage == KEY_ARMED);

endmodule // fcu_unlock

// ==== src/fcu_op_timer.sv ====
// Down-counting timer that paces each program or erase operation.
`timescale 1ns/1ps
module fcu_op_timer #(
    parameter int W = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic abort,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic done
);
    import fcu_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
        logic done;
    } fcu_timer_s;

    fcu_timer_s s_r;
    fcu_timer_s s_nxt;

    // A load of N raises done N+1 cycles after the start pulse.
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (abort) begin
            s_nxt.run = 1'b0;
            s_nxt.cnt = '0;
        end else if (start) begin
            s_nxt.run = 1'b1;
            s_nxt.cnt = load;
        end else if (s_r.run) begin
            if (s_r.cnt <= W'(1)) begin
                s_nxt.run = 1'b0;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - W'(1);
            end
        end
    end

    // Registers the timer state.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;

endmodule // fcu_op_timer

// ==== verification/fcu_flash_ctrl_bench.sv ====
// Self-checking bench for the program flash write and erase controller.
`timescale 1ns/1ps
module fcu_flash_ctrl_bench;
    import fcu_pkg::*;

    // ------------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------------
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic warm_rst = 1'b0;
    fcu_sfr_s sfr = '0;
    fcu_tbl_s tbl = '0;
    logic [7:0] flash_rdata = 8'h00;
    logic [7:0] sfr_rdata;
    fcu_flash_s flash;
    logic busy;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_prog = 0;
    int n_erase = 0;
    int n_rd = 0;
    logic chk_data = 1'b0;
    logic [21:0] exp_base = '0;
    logic [21:0] ptr = '0;
    logic [7:0] exp_hold [64];
    logic [7:0] rd_val;
    logic [7:0] bad_ctl [3] = '{8'h12, 8'h06, 8'h06};
    logic bad_key [3] = '{1'b1, 1'b0, 1'b1};
    logic bad_brk [3] = '{1'b0, 1'b0, 1'b1};

    // Short timer counts keep every program and erase timer wait a few cycles long.
    fcu_flash_ctrl #(.PROG_CYCLES(16'h0004), .ERASE_CYCLES(16'h0008)) dut (
        .clock(clock),
        .rst(rst),
        .warm_rst(warm_rst),
        .sfr(sfr),
        .tbl(tbl),
        .flash_rdata(flash_rdata),
        .sfr_rdata(sfr_rdata),
        .flash(flash),
        .busy(busy)
    );

    // The clock toggles every half period of 2.5 ns.
    always #2.5 clock = ~clock;

    // ------------------------------------------------------------------
    // Flash array stand-in and pulse monitor
    // ------------------------------------------------------------------
    // Pulses are sampled at the falling edge, where they have settled; the array
    // answers a read with a byte made from the address, otherwise a toggling value.
    always @(negedge clock) begin
        flash_rdata <= (flash.rd === 1'b1) ? (flash.addr[7:0] ^ 8'h3c) : ~flash_rdata;
        if (flash.prog === 1'b1) begin
            if (chk_data) begin
                check(24'(flash.addr), 24'(exp_base + 22'(n_prog)));
                check(24'(flash.wdata), 24'(exp_hold[flash.addr[5:0]]));
            end
            n_prog++;
        end
        if (flash.erase === 1'b1) begin
            check(24'(flash.addr), 24'({ptr[21:10], 10'h000}));
            n_erase++;
        end
        if (flash.rd === 1'b1) begin
            check(24'(flash.addr), 24'(ptr));
            n_rd++;
        end
    end

    // A hung run is cut short and counted as a mismatch.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic sfr_write(input logic [11:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr.addr = a;
        sfr.wdata = d;
        sfr.wr = 1'b1;
        @(negedge clock);
        sfr.wr = 1'b0;
    endtask

    // The answer stands for the one cycle after the taking edge.
    task automatic sfr_read(input logic [11:0] a, output logic [7:0] d);
        @(negedge clock);
        sfr.addr = a;
        sfr.rd = 1'b1;
        @(negedge clock);
        sfr.rd = 1'b0;
        d = sfr_rdata;
    endtask

    task automatic tbl_pulse(input logic wt);
        @(negedge clock);
        tbl.wt_op = wt;
        tbl.rd_op = ~wt;
        @(negedge clock);
        tbl = '0;
    endtask

    // The two top bits of the upper byte are written as ones on purpose.
    task automatic set_ptr(input logic [21:0] p);
        ptr = p;
        sfr_write(ADDR_PTR_LOW, p[7:0]);
        sfr_write(ADDR_PTR_HIGH, p[15:8]);
        sfr_write(ADDR_PTR_UPPER, {2'b11, p[21:16]});
    endtask

    // Optional unlock pattern, optionally broken by another write, then the control write.
    task automatic start_op(input logic [7:0] ctl, input logic keyed, input logic brk);
        n_prog = 0;
        n_erase = 0;
        if (keyed) sfr_write(ADDR_UNLOCK, UNLOCK_KEY_FIRST);
        if (brk) sfr_write(ADDR_PTR_LOW, ptr[7:0]);
        if (keyed) sfr_write(ADDR_UNLOCK, UNLOCK_KEY_SECOND);
        sfr_write(ADDR_CONTROL, ctl);
    endtask

    // Bounded wait for the end of an operation, then slack beyond the timer length.
    task automatic wait_idle();
        repeat (2) @(negedge clock);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clock);
        repeat (12) @(negedge clock);
        check(24'(busy), 24'h00_0000);
    endtask

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        // Power-up state, and the unlock port keeps nothing.
        sfr_read(ADDR_CONTROL, rd_val);
        check(24'(rd_val & 8'h0c), 24'h00_0000);
        sfr_write(ADDR_UNLOCK, UNLOCK_KEY_FIRST);
        sfr_read(ADDR_UNLOCK, rd_val);
        check(24'(rd_val), 24'h00_0000);
        // Pointer bytes read back, then one table read through the latch.
        set_ptr(22'h3f_1246);
        sfr_read(ADDR_PTR_UPPER, rd_val);
        check(24'(rd_val), 24'h00_003f);
        sfr_read(ADDR_PTR_LOW, rd_val);
        check(24'(rd_val), 24'h00_0046);
        n_rd = 0;
        tbl_pulse(1'b0);
        repeat (2) @(negedge clock);
        sfr_read(ADDR_LATCH, rd_val);
        check(24'(rd_val), 24'(ptr[7:0] ^ 8'h3c));
        check(24'(n_rd), 24'h00_0001);
        // Fill all 64 holding bytes through table writes.
        for (int i = 0; i < 64; i++) begin
            exp_hold[i] = 8'(i) ^ 8'ha5;
            sfr_write(ADDR_PTR_LOW, 8'(i));
            sfr_write(ADDR_LATCH, exp_hold[i]);
            tbl_pulse(1'b1);
        end
        // Block program; a zero written to the start bit mid-run changes nothing.
        set_ptr(22'h12_3485);
        exp_base = 22'h12_3480;
        chk_data = 1'b1;
        start_op(8'h06, 1'b1, 1'b0);
        sfr_read(ADDR_CONTROL, rd_val);
        check(24'(rd_val & 8'h0a), 24'h00_000a);
        sfr_write(ADDR_CONTROL, 8'h0c);
        sfr_read(ADDR_CONTROL, rd_val);
        check(24'(rd_val[BIT_START]), 24'h00_0001);
        wait_idle();
        check(24'(n_prog), 24'h00_0040);
        check(24'(n_erase), 24'h00_0000);
        sfr_read(ADDR_CONTROL, rd_val);
        check(24'(rd_val & 8'h0a), 24'h00_0000);
        // Word program from an odd pointer covers the even and odd byte.
        for (int i = 4; i < 6; i++) begin
            sfr_write(ADDR_PTR_LOW, 8'(i));
            sfr_write(ADDR_LATCH, exp_hold[i]);
            tbl_pulse(1'b1);
        end
        set_ptr(22'h12_3485);
        exp_base = 22'h12_3484;
        start_op(8'h26, 1'b1, 1'b0);
        wait_idle();
        check(24'(n_prog), 24'h00_0002);
        chk_data = 1'b0;
        // Erase of the block around the pointer.
        set_ptr(22'h12_37ff);
        start_op(8'h16, 1'b1, 1'b0);
        wait_idle();
        check(24'(n_erase), 24'h00_0001);
        check(24'(n_prog), 24'h00_0000);
        // Refused starts: no permit, no unlock, unlock broken by another write.
        for (int c = 0; c < 3; c++) begin
            start_op(bad_ctl[c], bad_key[c], bad_brk[c]);
            wait_idle();
            check(24'(n_prog + n_erase), 24'h00_0000);
            sfr_read(ADDR_CONTROL, rd_val);
            check(24'(rd_val & 8'h0a), 24'h00_0008);
        end
        // Warm reset in mid-block leaves the fault flag up and clears the rest.
        start_op(8'h06, 1'b1, 1'b0);
        repeat (10) @(negedge clock);
        warm_rst = 1'b1;
        @(negedge clock);
        warm_rst = 1'b0;
        sfr_read(ADDR_CONTROL, rd_val);
        check(24'(rd_val & 8'h0e), 24'h00_0008);
        check(24'(busy), 24'h00_0000);
        sfr_write(ADDR_CONTROL, 8'h00);
        sfr_read(ADDR_CONTROL, rd_val);
        check(24'(rd_val[BIT_FAULT]), 24'h00_0000);
        print_verdict();
    end
endmodule // fcu_flash_ctrl_bench
